// >>> logic/peripheral_soft_reset_control.sv
// Peripheral soft reset control: two software reset registers behind a
// classic Wishbone slave, driving per-peripheral reset lines.
// Assumes the capability masks come from logic on the same clock.
`timescale 1ns/100ps
module peripheral_soft_reset_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] capability_mask_two_i,
  input wire logic [31:0] capability_mask_four_i,
  output reset_ctrl_pkg::periph_resets_t periph_resets_o,
  output reset_ctrl_pkg::port_resets_t port_resets_o
);

  reset_ctrl_pkg::state_t state_reg;
  reset_ctrl_pkg::state_t state_next;

  logic req;
  logic wr_periph;
  logic wr_port;
  logic [31:0] byte_mask;
  logic [31:0] periph_wmask;
  logic [31:0] port_wmask;

  // Byte lanes expanded to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // New request only when no ack is standing, so each access acks once
  assign req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign wr_periph = req & wb_we_i &
    (wb_adr_i == reset_ctrl_pkg::PERIPH_RESET_OFFSET); // RULE_01
  assign wr_port = req & wb_we_i &
    (wb_adr_i == reset_ctrl_pkg::PORT_RESET_OFFSET); // RULE_02

  // Capability and reserved bits both gate what a write can touch
  assign periph_wmask = byte_mask & capability_mask_two_i &
    reset_ctrl_pkg::PERIPH_IMPL_MASK; // RULE_03
  assign port_wmask = byte_mask & capability_mask_four_i &
    reset_ctrl_pkg::PORT_IMPL_MASK; // RULE_04

  // Next-state logic for registers, bus answer and reset lines
  always_comb begin
    state_next = state_reg;
    state_next.ack = req;
    if (wr_periph) begin
      state_next.periph_ctrl = (state_reg.periph_ctrl & ~periph_wmask) |
        (wb_dat_i & periph_wmask); // RULE_03
    end
    if (wr_port) begin
      state_next.port_ctrl = (state_reg.port_ctrl & ~port_wmask) |
        (wb_dat_i & port_wmask); // RULE_04
    end
    // Reserved bits never hold state, so reads return zero there
    state_next.periph_ctrl = state_next.periph_ctrl &
      reset_ctrl_pkg::PERIPH_IMPL_MASK; // RULE_09
    state_next.port_ctrl = state_next.port_ctrl &
      reset_ctrl_pkg::PORT_IMPL_MASK; // RULE_08
    // Unmapped reads answer zero; writes there are dropped
    state_next.rdata = 32'h00000000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == reset_ctrl_pkg::PERIPH_RESET_OFFSET) begin
        state_next.rdata = state_reg.periph_ctrl;
      end else if (wb_adr_i == reset_ctrl_pkg::PORT_RESET_OFFSET) begin
        state_next.rdata = state_reg.port_ctrl;
      end
    end
    // Lines change in the same cycle as the register, held while bit is one
    state_next.periph_rst.analog_cmp_zero_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_CMP0]; // RULE_11
    state_next.periph_rst.sync_serial_zero_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_SSER0]; // RULE_11
    state_next.periph_rst.gp_counter_two_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_TMR2]; // RULE_05
    state_next.periph_rst.gp_counter_one_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_TMR1]; // RULE_05
    state_next.periph_rst.gp_counter_zero_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_TMR0]; // RULE_05
    state_next.periph_rst.two_wire_zero_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_TWI0]; // RULE_06
    state_next.periph_rst.async_serial_one_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_ASER1]; // RULE_07
    state_next.periph_rst.async_serial_zero_reset =
      state_next.periph_ctrl[reset_ctrl_pkg::BIT_ASER0]; // RULE_07
    state_next.port_rst = state_next.port_ctrl[4:0]; // RULE_08 RULE_10
  end

  // State register; synchronous reset clears both controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.periph_ctrl <= reset_ctrl_pkg::PERIPH_RESET_VALUE; // RULE_01
      state_reg.port_ctrl <= reset_ctrl_pkg::PORT_RESET_VALUE; // RULE_02
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o = state_reg.rdata;
  assign wb_ack_o = state_reg.ack;
  assign periph_resets_o = state_reg.periph_rst; // RULE_10
  assign port_resets_o = state_reg.port_rst;

  // Assertions: bus handshake
  // One ack per access; a held strobe must not see a double answer
  wb_ack_once_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood two cycles");

  ack_follows_req_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");

  ack_needs_req_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  // Read data stands only in the ack cycle; zero keeps the bus quiet
  rdata_idle_zero_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h00000000))
    else $error("read data not zero outside ack");

  // Assertions: read path
  read_periph_a: assert property (@(posedge clk_i) // RULE_01
    disable iff (rst_i)
    (req && !wb_we_i &&
      (wb_adr_i == reset_ctrl_pkg::PERIPH_RESET_OFFSET)) |=>
      (wb_dat_o == $past(state_reg.periph_ctrl)))
    else $error("first register read returned wrong data");

  read_port_a: assert property (@(posedge clk_i) // RULE_02
    disable iff (rst_i)
    (req && !wb_we_i &&
      (wb_adr_i == reset_ctrl_pkg::PORT_RESET_OFFSET)) |=>
      (wb_dat_o == $past(state_reg.port_ctrl)))
    else $error("port register read returned wrong data");

  // Unmapped offsets answer but carry no data
  read_unmapped_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (req && !wb_we_i &&
      (wb_adr_i != reset_ctrl_pkg::PERIPH_RESET_OFFSET) &&
      (wb_adr_i != reset_ctrl_pkg::PORT_RESET_OFFSET)) |=>
      (wb_dat_o == 32'h00000000))
    else $error("unmapped read returned data");

  // Assertions: reserved bits never hold state
  periph_reserved_a: assert property (@(posedge clk_i) // RULE_09
    disable iff (rst_i)
    (state_reg.periph_ctrl & ~reset_ctrl_pkg::PERIPH_IMPL_MASK) == '0)
    else $error("reserved bit set in first reset register");

  port_reserved_a: assert property (@(posedge clk_i) // RULE_08
    disable iff (rst_i)
    state_reg.port_ctrl[31:5] == '0)
    else $error("reserved bit set in port reset register");

  // Assertions: write masking by capability and byte lane
  cap_two_mask_a: assert property (@(posedge clk_i) // RULE_03
    disable iff (rst_i)
    wr_periph |=> ((state_reg.periph_ctrl ^ $past(state_reg.periph_ctrl))
      & ~$past(capability_mask_two_i)) == '0)
    else $error("masked bit changed in first reset register");

  cap_four_mask_a: assert property (@(posedge clk_i) // RULE_04
    disable iff (rst_i)
    wr_port |=> ((state_reg.port_ctrl ^ $past(state_reg.port_ctrl))
      & ~$past(capability_mask_four_i)) == '0)
    else $error("masked bit changed in port reset register");

  sel_lane_a: assert property (@(posedge clk_i) // RULE_03
    disable iff (rst_i)
    wr_periph |=> ((state_reg.periph_ctrl ^ $past(state_reg.periph_ctrl))
      & ~$past(byte_mask)) == '0)
    else $error("disabled byte lane changed in first reset register");

  // A permitted bit must take the written value, not merely stay put
  periph_lands_a: assert property (@(posedge clk_i) // RULE_03
    disable iff (rst_i)
    wr_periph |=> ((state_reg.periph_ctrl & $past(periph_wmask)) ==
      ($past(wb_dat_i) & $past(periph_wmask))))
    else $error("enabled bit not written in first reset register");

  port_lands_a: assert property (@(posedge clk_i) // RULE_04
    disable iff (rst_i)
    wr_port |=> ((state_reg.port_ctrl & $past(port_wmask)) ==
      ($past(wb_dat_i) & $past(port_wmask))))
    else $error("enabled bit not written in port reset register");

  // Reads and unmapped writes leave both registers alone
  periph_hold_a: assert property (@(posedge clk_i) // RULE_09
    disable iff (rst_i)
    !wr_periph |=> $stable(state_reg.periph_ctrl))
    else $error("first reset register changed without a write");

  port_hold_a: assert property (@(posedge clk_i) // RULE_09
    disable iff (rst_i)
    !wr_port |=> $stable(state_reg.port_ctrl))
    else $error("port reset register changed without a write");

  // Assertions: each reset line follows its control bit
  timer_zero_line_a: assert property (@(posedge clk_i) // RULE_05
    disable iff (rst_i)
    periph_resets_o.gp_counter_zero_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_TMR0])
    else $error("timer zero reset line disagrees with register");

  timer_one_line_a: assert property (@(posedge clk_i) // RULE_05
    disable iff (rst_i)
    periph_resets_o.gp_counter_one_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_TMR1])
    else $error("timer one reset line disagrees with register");

  timer_two_line_a: assert property (@(posedge clk_i) // RULE_05
    disable iff (rst_i)
    periph_resets_o.gp_counter_two_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_TMR2])
    else $error("timer two reset line disagrees with register");

  two_wire_line_a: assert property (@(posedge clk_i) // RULE_06
    disable iff (rst_i)
    periph_resets_o.two_wire_zero_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_TWI0])
    else $error("two-wire reset line disagrees with register");

  serial_line_a: assert property (@(posedge clk_i) // RULE_07
    disable iff (rst_i)
    periph_resets_o.async_serial_one_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_ASER1])
    else $error("serial one reset line disagrees with register");

  serial_zero_line_a: assert property (@(posedge clk_i) // RULE_07
    disable iff (rst_i)
    periph_resets_o.async_serial_zero_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_ASER0])
    else $error("serial zero reset line disagrees with register");

  sync_line_a: assert property (@(posedge clk_i) // RULE_11
    disable iff (rst_i)
    periph_resets_o.sync_serial_zero_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_SSER0])
    else $error("sync serial reset line disagrees with register");

  cmp_line_a: assert property (@(posedge clk_i) // RULE_11
    disable iff (rst_i)
    periph_resets_o.analog_cmp_zero_reset ==
      state_reg.periph_ctrl[reset_ctrl_pkg::BIT_CMP0])
    else $error("comparator reset line disagrees with register");

  port_line_a: assert property (@(posedge clk_i) // RULE_10
    disable iff (rst_i)
    port_resets_o == state_reg.port_ctrl[4:0])
    else $error("port reset lines disagree with register");

  // Lines must not glitch while software leaves the register alone
  lines_hold_a: assert property (@(posedge clk_i) // RULE_10
    disable iff (rst_i)
    !wr_periph |=> $stable(periph_resets_o))
    else $error("peripheral reset lines moved without a write");

  port_lines_hold_a: assert property (@(posedge clk_i) // RULE_10
    disable iff (rst_i)
    !wr_port |=> $stable(port_resets_o))
    else $error("port reset lines moved without a write");

  // Clearing a permitted bit releases the peripheral on the next edge
  timer_release_a: assert property (@(posedge clk_i) // RULE_10
    disable iff (rst_i)
    (wr_periph && periph_wmask[reset_ctrl_pkg::BIT_TMR0] &&
      !wb_dat_i[reset_ctrl_pkg::BIT_TMR0]) |=>
      !periph_resets_o.gp_counter_zero_reset)
    else $error("timer zero not released after clear");

  port_release_a: assert property (@(posedge clk_i) // RULE_10
    disable iff (rst_i)
    (wr_port && port_wmask[0] && !wb_dat_i[0]) |=>
      !port_resets_o.port_a_reset)
    else $error("port a not released after clear");

  // Assertions: reset values; no disable here, reset is the subject
  reset_clear_a: assert property (@(posedge clk_i) // RULE_01
    rst_i |=> (state_reg.periph_ctrl == '0))
    else $error("first reset register not zero after reset");

  reset_port_a: assert property (@(posedge clk_i) // RULE_02
    rst_i |=> (state_reg.port_ctrl == '0))
    else $error("port reset register not zero after reset");

  reset_lines_a: assert property (@(posedge clk_i) // RULE_10
    rst_i |=> (periph_resets_o == '0 && port_resets_o == '0 && !wb_ack_o))
    else $error("outputs not quiet after reset");

  // Covers for the main scenarios
  write_periph_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_periph ##1 (state_reg.periph_ctrl != '0));

  write_port_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_port ##1 (state_reg.port_ctrl != '0));

  release_c: cover property (@(posedge clk_i) disable iff (rst_i)
    port_resets_o.port_a_reset ##[1:20] !port_resets_o.port_a_reset);

  masked_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_periph && ((wb_dat_i & ~capability_mask_two_i &
      reset_ctrl_pkg::PERIPH_IMPL_MASK) != '0));

  // Partial lane write, the case a read-modify-write avoids
  lane_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_periph && (wb_sel_i != 4'hF));

endmodule

// >>> pkg/reset_ctrl_pkg.sv
// Package for the peripheral soft reset control block: offsets, fields,
// reset values and the carrier structs shared by design and bench.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
// How it works
// RULE_01: First reset register sits at byte offset 0x044, resets to zero.
// RULE_02: Port reset register sits at byte offset 0x048, resets to zero.
// RULE_03: First register writes change only bits present in capability two.
// RULE_04: Port register writes change only bits present in capability four.
// RULE_05: Bits 18, 17, 16 reset timers two, one and zero.
// RULE_06: Bit 12 resets two-wire bus unit zero.
// RULE_07: Bits 1 and 0 reset asynchronous serial units one and zero.
// RULE_08: Port register bits 4..0 reset ports E..A; bits 31:5 read zero.
// RULE_09: Reserved bits read zero, ignore writes; software writes back reads.
// RULE_10: A peripheral stays in reset while its bit is one.
// RULE_11: Bit 24 resets analog comparator zero, bit 4 the sync serial unit.
package reset_ctrl_pkg;

  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
  localparam logic [11:0] PERIPH_RESET_OFFSET = 12'h044;
  localparam logic [11:0] PORT_RESET_OFFSET = 12'h048;
  localparam logic [31:0] PERIPH_RESET_VALUE = 32'h00000000;
  localparam logic [31:0] PORT_RESET_VALUE = 32'h00000000;

  // Implemented bit positions of the first register
  localparam int unsigned BIT_CMP0 = 24;
  localparam int unsigned BIT_TMR2 = 18;
  localparam int unsigned BIT_TMR1 = 17;
  localparam int unsigned BIT_TMR0 = 16;
  localparam int unsigned BIT_TWI0 = 12;
  localparam int unsigned BIT_SSER0 = 4;
  localparam int unsigned BIT_ASER1 = 1;
  localparam int unsigned BIT_ASER0 = 0;
  localparam logic [31:0] PERIPH_IMPL_MASK = 32'h01071013;
  localparam logic [31:0] PORT_IMPL_MASK = 32'h0000001F;

  // Reset lines fanned out to the peripherals
  typedef struct packed {
    logic analog_cmp_zero_reset;
    logic gp_counter_two_reset;
    logic gp_counter_one_reset;
    logic gp_counter_zero_reset;
    logic two_wire_zero_reset;
    logic sync_serial_zero_reset;
    logic async_serial_one_reset;
    logic async_serial_zero_reset;
  } periph_resets_t;

  typedef struct packed {
    logic port_e_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_b_reset;
    logic port_a_reset;
  } port_resets_t;

  // Whole state of the block
  typedef struct packed {
    logic [31:0] periph_ctrl;
    logic [31:0] port_ctrl;
    logic ack;
    logic [31:0] rdata;
    periph_resets_t periph_rst;
    port_resets_t port_rst;
  } state_t;

endpackage

// >>> tb/tb_peripheral_soft_reset_control.sv
// Self-checking bench for the peripheral soft reset control block.
// Assumes a classic Wishbone slave that acks one cycle after the request.
`timescale 1ns/100ps
module tb_peripheral_soft_reset_control;
  localparam logic [11:0] OFF1 = reset_ctrl_pkg::PERIPH_RESET_OFFSET;
  localparam logic [11:0] OFF2 = reset_ctrl_pkg::PORT_RESET_OFFSET;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000, cap2 = 32'h00000000;
  logic [31:0] cap4 = 32'h00000000, rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  reset_ctrl_pkg::periph_resets_t prst;
  reset_ctrl_pkg::port_resets_t trst;
  int n_errors = 0, samples_checked = 0;
  int bits [8] = '{0, 1, 4, 12, 16, 17, 18, 24};

  peripheral_soft_reset_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .capability_mask_two_i(cap2),
    .capability_mask_four_i(cap4), .periph_resets_o(prst),
    .port_resets_o(trst));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // One Wishbone cycle; request held until ack is sampled
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) n_errors++;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'hF, 32'h00000000);
    chk(rdat, exp);
  endtask

  // Reset lines expected from a first-register value, own mapping
  function automatic logic [31:0] pexp(input logic [31:0] v);
    return {24'h0, v[24], v[18], v[17], v[16], v[12], v[4], v[1], v[0]};
  endfunction

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({24'h0, prst}, 32'h00000000);
    rd_chk(OFF1, 32'h00000000);
    rd_chk(OFF2, 32'h00000000);
    cap2 <= 32'hFFFFFFFF;
    cap4 <= 32'hFFFFFFFF;
    // Walk each control bit alone, checking its line
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, OFF1, 4'hF, 32'h1 << bits[i]);
      rd_chk(OFF1, 32'h1 << bits[i]);
      chk({24'h0, prst}, 32'h1 << i);
    end
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, OFF2, 4'hF, 32'h1 << i);
      chk({27'h0, trst}, 32'h1 << i);
    end
    xfer(1'b1, OFF1, 4'hF, 32'hFFFFFFFF);
    rd_chk(OFF1, reset_ctrl_pkg::PERIPH_IMPL_MASK);
    xfer(1'b1, OFF2, 4'hF, 32'hFFFFFFFF);
    rd_chk(OFF2, 32'h0000001F);
    // Absent peripherals keep their old value when cleared
    cap2 <= 32'h00010001;
    cap4 <= 32'h00000005;
    xfer(1'b1, OFF1, 4'hF, 32'h00000000);
    rd_chk(OFF1, 32'h01061012);
    chk({24'h0, prst}, pexp(32'h01061012));
    xfer(1'b1, OFF2, 4'hF, 32'h00000000);
    rd_chk(OFF2, 32'h0000001A);
    // Only the enabled byte lane is written
    cap2 <= 32'hFFFFFFFF;
    xfer(1'b1, OFF1, 4'h1, 32'h00000000);
    rd_chk(OFF1, 32'h01061000);
    // Unmapped offset reads zero and drops the write
    xfer(1'b1, 12'h040, 4'hF, 32'hFFFFFFFF);
    rd_chk(12'h040, 32'h00000000);
    rd_chk(OFF1, 32'h01061000);
    // Second reset in mid-run clears everything again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFF1, 32'h00000000);
    rd_chk(OFF2, 32'h00000000);
    chk({19'h0, prst, trst}, 32'h00000000);
    test_done();
  end
endmodule
